// ### shared/hwa_pkg.sv
// Purpose: shared constants and decoding for the hardware monitor alert block
// Assumes: 8-bit register port fed by the serial bus engine, one clock
// Notes:   status bits are kept as one flat 24-bit vector, 8 bits per register
// ****************************************************************************
// Overview of operation
// - reading outside or equal to its low/high limit sets its status bit
// - status read clears only bits whose cause has gone away
// - status registers ignore writes, zero on reset and soft init
// - fault on an enabled remote diode sets its fault status bit while running
// - enabled diode fault forces 80h reading, setting zone temperature bit
// - zone reading of 80h drives that zone's fans to full speed
// - disabled diode fault loads 00h and sets no fault bit
// - alert pin acts as interrupt only while configuration bit 1 is set
// - alert may go active only while special function bit 2 is set
// - temperature bits reach the alert only with enable bit 5 set
// - voltage bits in all status registers reach alert with bit 3
// - fan tachometer bits reach the alert only with enable bit 0
// - active-low alert held low while any enabled status bit is set
// - diode fault bits never assert the alert themselves
// - host may release the alert with an alert response read
// - alert never active while monitoring is stopped or in low power
// - start bit zero enters low power; bit 0 picks sleep or shutdown
// - low power resets no register and runs all fans at full duty
// - low power halts conversions; register access keeps working
// - supply codes are 8 bits with nominal supply at 192
// - five voltage-id inputs are captured into a readable register
// - alert response acknowledge clears the global alert enable bit
// ****************************************************************************
package hwa_pkg;
  // ********************
  // register map
  // ********************
  localparam logic [7:0] OFF_RUN    = 8'h40;
  localparam logic [7:0] OFF_STAT1  = 8'h41;
  localparam logic [7:0] OFF_STAT2  = 8'h42;
  localparam logic [7:0] OFF_VID    = 8'h43;
  localparam logic [7:0] OFF_LIMIT  = 8'h44;
  localparam logic [7:0] OFF_SF     = 8'h7c;
  localparam logic [7:0] OFF_STAT3  = 8'h7d;
  localparam logic [7:0] OFF_CFG    = 8'h7f;
  localparam logic [7:0] OFF_FTE    = 8'h80;
  localparam logic [7:0] RST_REG    = 8'h00;
  // ********************
  // field positions
  // ********************
  localparam int START_BIT     = 0;
  localparam int SHUTDOWN_SEL  = 0;
  localparam int GLOBAL_EN     = 2;
  localparam int VOLT_EN       = 3;
  localparam int PIN_EN        = 1;
  localparam int SOFT_INIT     = 7;
  localparam int TEMP_EN       = 5;
  localparam int TACH_EN       = 0;
  localparam int FLAT_DIODE    = 9;
  localparam int FLAT_TACH     = 11;
  // ********************
  // channels, codes, masks
  // ********************
  localparam int NUM_CHAN = 11;
  localparam int LIM_AW   = 4;
  localparam logic [3:0] CH_ZONE1 = 4'h0;
  localparam logic [3:0] CH_ZONE2 = 4'h1;
  localparam logic [3:0] CH_ZONE3 = 4'h8;
  localparam logic [7:0] SENSOR_ERR    = 8'h80;
  localparam logic [7:0] DISABLED_CODE = 8'h00;
  localparam logic [7:0] NOMINAL_CODE  = 8'hc0;
  localparam logic [23:0] TEMP_MASK  = 24'h000070;
  localparam logic [23:0] VOLT_MASK  = 24'h03018f;
  localparam logic [23:0] TACH_MASK  = 24'h007800;
  localparam logic [23:0] DIODE_MASK = 24'h000600;

  // channel (sampling order) to flat status bit index
  function automatic logic [4:0] chan_to_flat(input logic [3:0] ch);
    case (ch)
      4'h0:    chan_to_flat = 5'h04;
      4'h1:    chan_to_flat = 5'h05;
      4'h2:    chan_to_flat = 5'h02;
      4'h3:    chan_to_flat = 5'h07;
      4'h4:    chan_to_flat = 5'h03;
      4'h5:    chan_to_flat = 5'h08;
      4'h6:    chan_to_flat = 5'h00;
      4'h7:    chan_to_flat = 5'h01;
      4'h8:    chan_to_flat = 5'h06;
      4'h9:    chan_to_flat = 5'h10;
      default: chan_to_flat = 5'h11;
    endcase
  endfunction : chan_to_flat

  function automatic logic is_temp(input logic [3:0] ch);
    is_temp = (ch == CH_ZONE1) || (ch == CH_ZONE2) || (ch == CH_ZONE3);
  endfunction : is_temp
endpackage : hwa_pkg

// ### shared/hwa_lim_if.sv
// Purpose: carrier between the alert logic and its limit memory
// Assumes: one word per channel, low limit in bits 7:0, high in 15:8
// Notes:   both read ports give registered data one cycle after the address
`timescale 1ns/1ps
interface hwa_lim_if;
  logic                        we;
  logic                        we_hi;
  logic [hwa_pkg::LIM_AW-1:0]  waddr;
  logic [7:0]                  wdata;
  logic [hwa_pkg::LIM_AW-1:0]  caddr;
  logic [15:0]                 cq;
  logic [hwa_pkg::LIM_AW-1:0]  haddr;
  logic [15:0]                 hq;
  modport mem (input we, we_hi, waddr, wdata, caddr, haddr, output cq, hq);
  modport ctl (output we, we_hi, waddr, wdata, caddr, haddr, input cq, hq);
endinterface : hwa_lim_if

// ### verilog/hwa_limit_mem.sv
// Purpose: low/high limit store, one 16-bit word per monitored channel
// Assumes: byte writes select the half by we_hi
// Notes:   contents are not cleared by reset; software programs limits first
`timescale 1ns/1ps
module hwa_limit_mem #(
  parameter int DEPTH = hwa_pkg::NUM_CHAN
) (
  input  wire logic  CLK_SYS,
  hwa_lim_if.mem     lim
);
  logic [15:0] mem [DEPTH];

  always_ff @(posedge CLK_SYS) begin
    if (lim.we && (int'(lim.waddr) < DEPTH)) begin
      if (lim.we_hi) begin
        mem[lim.waddr][15:8] <= lim.wdata;
      end else begin
        mem[lim.waddr][7:0] <= lim.wdata;
      end
    end
    lim.cq <= mem[lim.caddr];
    lim.hq <= mem[lim.haddr];
  end
endmodule : hwa_limit_mem

// ### verilog/hwa_alert_top.sv
// Purpose: status latching, alert gating, low power and reading path
// Assumes: register port driven by the serial bus engine on CLK_SYS
// Notes:   register reads answer two cycles after REG_RD
`timescale 1ns/1ps
module hwa_alert_top #(
  parameter int NUM_FANS = 3
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST,
  input  wire logic [7:0]            REG_ADDR,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  input  wire logic [7:0]            REG_WDATA,
  output      logic [7:0]            REG_RDATA,
  output      logic                  REG_RVALID,
  input  wire logic                  CONV_VALID,
  input  wire logic [3:0]            CONV_CHAN,
  input  wire logic [9:0]            CONV_DATA,
  input  wire logic [1:0]            DIODE_FAULT,
  input  wire logic [1:0]            DIODE_EN,
  input  wire logic [3:0]            TACH_ERR,
  input  wire logic [4:0]            CPU_VOLTAGE_CODE_INPUTS,
  input  wire logic [2*NUM_FANS-1:0] FAN_ZONE,
  input  wire logic                  ARA_ACK,
  output      logic                  ALERT_N,
  output      logic                  READING_VALID,
  output      logic [3:0]            READING_CHAN,
  output      logic [7:0]            READING_DATA,
  output      logic [NUM_FANS-1:0]   FAN_FULL,
  output      logic                  CONV_HALT,
  output      logic                  BIAS_OFF
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0]          run;
    logic [7:0]          sf;
    logic [7:0]          cfg;
    logic [7:0]          fte;
    logic [4:0]          vid;
    logic [4:0]          vid_m;
    logic [4:0]          vid_s;
    logic [1:0]          fault_m;
    logic [1:0]          fault_s;
    logic [23:0]         status;
    logic [23:0]         active;
    logic [2:0]          zone_err;
    logic                c_valid;
    logic [3:0]          c_chan;
    logic [7:0]          c_code;
    logic                rd_pend;
    logic                rd_mem;
    logic                rd_hi;
    logic [7:0]          rd_local;
    logic                rvalid;
    logic [7:0]          rdata;
    logic                rv;
    logic [3:0]          r_chan;
    logic [7:0]          r_data;
    logic [NUM_FANS-1:0] fan_full;
    logic                halt;
    logic                bias_off;
    logic                alert_n;
  } hwa_state_t;

  hwa_state_t  st;
  hwa_state_t  next_st;
  logic        running;
  logic [23:0] act;
  logic [23:0] set;
  logic [23:0] clr;
  logic [23:0] en_mask;
  logic        cmp_hit;
  logic [4:0]  cmp_idx;
  logic [7:0]  lim_off;

  hwa_lim_if lim ();

  hwa_limit_mem #(
    .DEPTH (hwa_pkg::NUM_CHAN)
  ) u_lim (
    .CLK_SYS (CLK_SYS),
    .lim     (lim)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  // round the 10-bit converter fraction to 8 bits, saturating at top
  function automatic logic [7:0] scale_volt(input logic [9:0] raw);
    logic [10:0] sum;
    sum = {1'b0, raw} + 11'h002;
    scale_volt = sum[10] ? 8'hff : sum[9:2];
  endfunction : scale_volt

  // equality with a limit counts as a violation
  function automatic logic out_of_limit(input logic [7:0] code,
                                        input logic [15:0] lim_w,
                                        input logic        sgn);
    if (sgn) begin
      out_of_limit = ($signed(code) <= $signed(lim_w[7:0])) ||
                     ($signed(code) >= $signed(lim_w[15:8]));
    end else begin
      out_of_limit = (code <= lim_w[7:0]) || (code >= lim_w[15:8]);
    end
  endfunction : out_of_limit

  assign running   = st.run[hwa_pkg::START_BIT];
  assign lim_off   = REG_ADDR - hwa_pkg::OFF_LIMIT;
  assign lim.we    = REG_WR && (REG_ADDR >= hwa_pkg::OFF_LIMIT) &&
                     (lim_off < 8'(2 * hwa_pkg::NUM_CHAN));
  assign lim.we_hi = lim_off[0];
  assign lim.waddr = lim_off[4:1];
  assign lim.wdata = REG_WDATA;
  assign lim.haddr = lim_off[4:1];
  assign lim.caddr = CONV_CHAN;
  assign cmp_idx   = hwa_pkg::chan_to_flat(st.c_chan);
  assign cmp_hit   = st.c_valid &&
                     out_of_limit(st.c_code, lim.cq,
                                  hwa_pkg::is_temp(st.c_chan));

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    act     = st.active;
    set     = '0;
    clr     = '0;
    // fault pins cross in through two flops, voltage-id pins through three, before anything looks at them
    next_st.fault_m = DIODE_FAULT;
    next_st.fault_s = st.fault_m;
    next_st.vid_m   = CPU_VOLTAGE_CODE_INPUTS;
    next_st.vid_s   = st.vid_m;
    next_st.vid     = st.vid_s;

    // register writes; status offsets have no write decode at all
    if (REG_WR) begin
      if (REG_ADDR == hwa_pkg::OFF_RUN) begin
        next_st.run = REG_WDATA;
      end else if (REG_ADDR == hwa_pkg::OFF_SF) begin
        next_st.sf = REG_WDATA;
      end else if (REG_ADDR == hwa_pkg::OFF_CFG) begin
        next_st.cfg = REG_WDATA;
      end else if (REG_ADDR == hwa_pkg::OFF_FTE) begin
        next_st.fte = REG_WDATA;
      end
    end
    // acknowledge of the alert response address drops the global enable
    if (ARA_ACK && !st.alert_n) begin
      next_st.sf[hwa_pkg::GLOBAL_EN] = 1'b0;
    end

    // conversion result: substitute diode fault codes, scale supplies
    next_st.c_valid = CONV_VALID && running &&
                      (int'(CONV_CHAN) < hwa_pkg::NUM_CHAN);
    next_st.c_chan  = CONV_CHAN;
    if (CONV_CHAN == hwa_pkg::CH_ZONE1 && st.fault_s[0]) begin
      next_st.c_code = DIODE_EN[0] ? hwa_pkg::SENSOR_ERR
                                   : hwa_pkg::DISABLED_CODE;
    end else if (CONV_CHAN == hwa_pkg::CH_ZONE3 && st.fault_s[1]) begin
      next_st.c_code = DIODE_EN[1] ? hwa_pkg::SENSOR_ERR
                                   : hwa_pkg::DISABLED_CODE;
    end else if (hwa_pkg::is_temp(CONV_CHAN)) begin
      next_st.c_code = CONV_DATA[7:0];
    end else begin
      next_st.c_code = scale_volt(CONV_DATA);
    end

    // limit comparison one cycle later, when the limit word is out
    next_st.rv     = st.c_valid;
    next_st.r_chan = st.c_chan;
    next_st.r_data = st.c_code;
    if (st.c_valid) begin
      act[cmp_idx] = cmp_hit;
      set[cmp_idx] = cmp_hit;
      if (st.c_chan == hwa_pkg::CH_ZONE1) begin
        next_st.zone_err[0] = (st.c_code == hwa_pkg::SENSOR_ERR);
      end
      if (st.c_chan == hwa_pkg::CH_ZONE2) begin
        next_st.zone_err[1] = (st.c_code == hwa_pkg::SENSOR_ERR);
      end
      if (st.c_chan == hwa_pkg::CH_ZONE3) begin
        next_st.zone_err[2] = (st.c_code == hwa_pkg::SENSOR_ERR);
      end
    end

    // diode faults and tach errors are level sources
    for (int i = 0; i < 2; i++) begin
      act[hwa_pkg::FLAT_DIODE+i] = st.fault_s[i] && DIODE_EN[i];
      set[hwa_pkg::FLAT_DIODE+i] = act[hwa_pkg::FLAT_DIODE+i] &&
                                   running;
    end
    act[hwa_pkg::FLAT_TACH +: 4] = TACH_ERR;
    set[hwa_pkg::FLAT_TACH +: 4] = running ? TACH_ERR : 4'h0;
    next_st.active = act;

    // clear on read, only where the cause is gone; a new set wins
    if (REG_RD) begin
      if (REG_ADDR == hwa_pkg::OFF_STAT1) begin
        clr[7:0] = 8'hff;
      end else if (REG_ADDR == hwa_pkg::OFF_STAT2) begin
        clr[15:8] = 8'hff;
      end else if (REG_ADDR == hwa_pkg::OFF_STAT3) begin
        clr[23:16] = 8'hff;
      end
    end
    next_st.status = (st.status & ~(clr & ~act)) | set;

    // read path, two cycles: capture, then present
    next_st.rd_pend = REG_RD;
    next_st.rd_mem  = lim.we || (REG_RD && (REG_ADDR >= hwa_pkg::OFF_LIMIT)
                      && (lim_off < 8'(2 * hwa_pkg::NUM_CHAN)));
    next_st.rd_hi   = lim_off[0];
    if (REG_ADDR == hwa_pkg::OFF_RUN) begin
      next_st.rd_local = st.run;
    end else if (REG_ADDR == hwa_pkg::OFF_STAT1) begin
      next_st.rd_local = st.status[7:0];
    end else if (REG_ADDR == hwa_pkg::OFF_STAT2) begin
      next_st.rd_local = st.status[15:8];
    end else if (REG_ADDR == hwa_pkg::OFF_VID) begin
      next_st.rd_local = {3'h0, st.vid};
    end else if (REG_ADDR == hwa_pkg::OFF_SF) begin
      next_st.rd_local = st.sf;
    end else if (REG_ADDR == hwa_pkg::OFF_STAT3) begin
      next_st.rd_local = st.status[23:16];
    end else if (REG_ADDR == hwa_pkg::OFF_CFG) begin
      next_st.rd_local = st.cfg;
    end else if (REG_ADDR == hwa_pkg::OFF_FTE) begin
      next_st.rd_local = st.fte;
    end else begin
      next_st.rd_local = 8'h00;
    end
    next_st.rvalid = st.rd_pend;
    if (!st.rd_pend) begin
      next_st.rdata = 8'h00;
    end else if (st.rd_mem) begin
      next_st.rdata = st.rd_hi ? lim.hq[15:8] : lim.hq[7:0];
    end else begin
      next_st.rdata = st.rd_local;
    end

    // alert: per-class enables, diode faults never in the mask
    en_mask = (st.fte[hwa_pkg::TEMP_EN] ? hwa_pkg::TEMP_MASK : 24'h0) |
              (st.sf[hwa_pkg::VOLT_EN]  ? hwa_pkg::VOLT_MASK : 24'h0) |
              (st.fte[hwa_pkg::TACH_EN] ? hwa_pkg::TACH_MASK : 24'h0);
    next_st.alert_n = !((|(st.status & en_mask)) &&
                        st.cfg[hwa_pkg::PIN_EN] &&
                        st.sf[hwa_pkg::GLOBAL_EN] &&
                        running);

    // low power: fans to full, converter held, no register touched
    for (int f = 0; f < NUM_FANS; f++) begin
      next_st.fan_full[f] = !running ||
        (FAN_ZONE[2*f +: 2] != 2'h0 &&
         st.zone_err[FAN_ZONE[2*f +: 2] - 2'h1]);
    end
    next_st.halt     = !running;
    next_st.bias_off = !running && st.sf[hwa_pkg::SHUTDOWN_SEL];

    // soft init: self-clearing, resets every register but readings, limits and the voltage-id capture
    if (st.cfg[hwa_pkg::SOFT_INIT]) begin
      next_st.run    = hwa_pkg::RST_REG;
      next_st.sf     = hwa_pkg::RST_REG;
      next_st.cfg    = hwa_pkg::RST_REG;
      next_st.fte    = hwa_pkg::RST_REG;
      next_st.status = 24'h0;
      next_st.active = 24'h0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st          <= '0;
      st.alert_n  <= 1'b1;
      st.fan_full <= '1;
      st.halt     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign REG_RDATA     = st.rdata;
  assign REG_RVALID    = st.rvalid;
  assign ALERT_N       = st.alert_n;
  assign READING_VALID = st.rv;
  assign READING_CHAN  = st.r_chan;
  assign READING_DATA  = st.r_data;
  assign FAN_FULL      = st.fan_full;
  assign CONV_HALT     = st.halt;
  assign BIAS_OFF      = st.bias_off;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_limit_hit_sets: assert property (
    cmp_hit && !st.cfg[hwa_pkg::SOFT_INIT] |=> st.status[$past(cmp_idx)])
    else $error("limit violation did not set status");
  a_read_keeps_live: assert property (
    REG_RD && REG_ADDR == hwa_pkg::OFF_STAT2 && st.status[11] &&
    TACH_ERR[0] && !st.cfg[hwa_pkg::SOFT_INIT] |=> st.status[11])
    else $error("active tach bit cleared by read");
  a_read_clears_idle: assert property (
    REG_RD && REG_ADDR == hwa_pkg::OFF_STAT2 && !TACH_ERR[0]
    |=> !st.status[11])
    else $error("idle tach bit survived read");
  a_status_no_write: assert property (
    REG_WR && REG_ADDR == hwa_pkg::OFF_STAT1 && st.status[7:0] == 8'h00
    && set[7:0] == 8'h00 |=> st.status[7:0] == 8'h00)
    else $error("write changed status");
  a_init_clears: assert property (
    st.cfg[hwa_pkg::SOFT_INIT] |=> st.status == 24'h0 && st.cfg == 8'h00)
    else $error("soft init left status or config");
  a_fault_bit_set: assert property (
    st.fault_s[0] && DIODE_EN[0] && running &&
    !st.cfg[hwa_pkg::SOFT_INIT] |=> st.status[hwa_pkg::FLAT_DIODE])
    else $error("diode fault bit not set");
  a_fault_code_80: assert property (
    CONV_VALID && running && CONV_CHAN == hwa_pkg::CH_ZONE1 &&
    st.fault_s[0] && DIODE_EN[0]
    |-> ##2 READING_VALID && READING_DATA == hwa_pkg::SENSOR_ERR)
    else $error("faulted zone reading not 80h");
  a_fault_code_00: assert property (
    CONV_VALID && running && CONV_CHAN == hwa_pkg::CH_ZONE1 &&
    st.fault_s[0] && !DIODE_EN[0]
    |-> ##2 READING_VALID && READING_DATA == hwa_pkg::DISABLED_CODE)
    else $error("disabled diode reading not 00h");
  a_pin_gate: assert property (
    !st.cfg[hwa_pkg::PIN_EN] |=> ALERT_N)
    else $error("alert active with pin disabled");
  a_global_gate: assert property (
    !st.sf[hwa_pkg::GLOBAL_EN] |=> ALERT_N)
    else $error("alert active with global enable off");
  a_stop_gate: assert property (
    !running |=> ALERT_N)
    else $error("alert active while stopped");
  a_diode_no_alert: assert property (
    (st.status & ~hwa_pkg::DIODE_MASK) == 24'h0 |=> ALERT_N)
    else $error("diode fault alone asserted alert");
  a_ara_release: assert property (
    ARA_ACK && !ALERT_N && !REG_WR
    |=> !st.sf[hwa_pkg::GLOBAL_EN] ##1 ALERT_N)
    else $error("alert response did not release alert");
  a_low_power_fans: assert property (
    !running |=> &FAN_FULL && CONV_HALT)
    else $error("fans not full in low power");
  a_set_wins_read: assert property (
    set[4] && clr[4] && !st.cfg[hwa_pkg::SOFT_INIT] |=> st.status[4])
    else $error("event lost on read");
  a_set_wins_tach: assert property (
    set[hwa_pkg::FLAT_TACH] && clr[hwa_pkg::FLAT_TACH] &&
    !st.cfg[hwa_pkg::SOFT_INIT] |=> st.status[hwa_pkg::FLAT_TACH])
    else $error("tach event lost on read");

  c_alert_asserted: cover property (running ##1 !ALERT_N);
  c_read_clear: cover property (st.status[4] ##1 REG_RD ##1 !st.status[4]);
  c_ara_release: cover property (!ALERT_N && ARA_ACK ##2 ALERT_N);
endmodule : hwa_alert_top

// ### dv/hwa_host_model.sv
// Purpose: host side of the register port and the alert response call
// Assumes: one request at a time, requests launched on rising edges
// Notes:   a read that gets no answer returns all-x to the caller
`timescale 1ns/1ps
module hwa_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  output      logic [7:0] addr,
  output      logic       wr,
  output      logic       rd,
  output      logic [7:0] wdata,
  output      logic       ara
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    ara = 1'b0;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    // bounded wait: answer expected two cycles after the request
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      if (rvalid === 1'b1) begin
        d = rdata;
        break;
      end
    end
  endtask : read_reg
  // one-cycle acknowledge of the alert response address
  task automatic alert_response();
    @(posedge clk);
    ara <= 1'b1;
    @(posedge clk);
    ara <= 1'b0;
  endtask : alert_response
endmodule : hwa_host_model

// ### dv/testbench.sv
// Purpose: self-checking bench for the monitor status and alert logic
// Assumes: host model drives the register port; bench drives the sources
// Notes:   an unknown result ends the run, so hung waits are caught too
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, cv = 1'b0, ara, wr, rd, rdv, alert_n;
  logic [7:0] addr, wdata, rdata, rdat;
  logic [3:0] cch = 4'h0, tach = 4'h0, rch;
  logic [9:0] cdat = 10'h000;
  logic [1:0] dfault = 2'b00, den = 2'b00;
  logic [4:0] vid = 5'h00;
  logic [5:0] fzone = 6'h01;
  logic rvl, halt, bias;
  logic [2:0] ffull;
  int fails = 0, cmp_count = 0;
  always #5 clk = ~clk;
  hwa_host_model u_host (.clk(clk), .rdata(rdata), .rvalid(rdv),
    .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .ara(ara));
  hwa_alert_top #(.NUM_FANS(3)) u_dut (.CLK_SYS(clk), .RST(rst),
    .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .REG_RVALID(rdv), .CONV_VALID(cv),
    .CONV_CHAN(cch), .CONV_DATA(cdat), .DIODE_FAULT(dfault),
    .DIODE_EN(den), .TACH_ERR(tach), .CPU_VOLTAGE_CODE_INPUTS(vid),
    .FAN_ZONE(fzone), .ARA_ACK(ara), .ALERT_N(alert_n),
    .READING_VALID(rvl), .READING_CHAN(rch), .READING_DATA(rdat),
    .FAN_FULL(ffull), .CONV_HALT(halt), .BIAS_OFF(bias));
  task automatic summarize();
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      if (^g === 1'bx) summarize();
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.read_reg(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask : rc
  task automatic pin(input logic [7:0] e);
    repeat (3) @(negedge clk);
    chk("alert_n", e, {7'h00, alert_n});
  endtask : pin
  task automatic conv(input logic [3:0] c, input logic [9:0] d,
                      input logic [7:0] e);
    logic [7:0] g;
    g = 8'hxx;
    @(posedge clk);
    cv <= 1'b1;
    cch <= c;
    cdat <= d;
    @(posedge clk);
    cv <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      if (rvl === 1'b1) g = rdat;
    end
    chk("reading", e, g);
  endtask : conv
  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    rc(8'h41, 8'h00);
    rc(8'h42, 8'h00);
    rc(8'h7d, 8'h00);
    u_host.write_reg(8'h41, 8'hff);
    rc(8'h41, 8'h00);
  endtask : t_reset
  task automatic t_volt();
    u_host.write_reg(8'h48, 8'h10);
    u_host.write_reg(8'h49, 8'hf0);
    u_host.write_reg(8'h7f, 8'h02);
    u_host.write_reg(8'h7c, 8'h04);
    u_host.write_reg(8'h40, 8'h01);
    conv(4'h2, 10'd768, 8'hc0);
    conv(4'h2, 10'd960, 8'hf0);
    pin(8'h01);
    u_host.write_reg(8'h7c, 8'h0c);
    pin(8'h00);
    rc(8'h41, 8'h04);
    rc(8'h41, 8'h04);
    conv(4'h2, 10'd768, 8'hc0);
    rc(8'h41, 8'h04);
    rc(8'h41, 8'h00);
    pin(8'h01);
  endtask : t_volt
  task automatic t_diode();
    u_host.write_reg(8'h44, 8'hc0);
    u_host.write_reg(8'h45, 8'h7f);
    @(posedge clk);
    den <= 2'b01;
    dfault <= 2'b01;
    repeat (4) @(posedge clk);
    conv(4'h0, 10'h019, 8'h80);
    rc(8'h42, 8'h02);
    rc(8'h41, 8'h10);
    chk("fan_full", 8'h01, {5'h00, ffull});
    pin(8'h01);
    u_host.write_reg(8'h80, 8'h20);
    pin(8'h00);
    u_host.alert_response();
    pin(8'h01);
    rc(8'h7c, 8'h08);
    @(posedge clk);
    den <= 2'b00;
    conv(4'h0, 10'h019, 8'h00);
  endtask : t_diode
  task automatic t_tach();
    u_host.write_reg(8'h80, 8'h01);
    @(posedge clk);
    tach <= 4'h1;
    u_host.write_reg(8'h7c, 8'h0c);
    pin(8'h00);
    // global enable dropped around the reads; after re-enable the pin must stay released
    u_host.write_reg(8'h7c, 8'h08);
    rc(8'h42, 8'h0a);
    @(posedge clk);
    tach <= 4'h0;
    rc(8'h42, 8'h08);
    rc(8'h42, 8'h00);
    u_host.write_reg(8'h7c, 8'h0c);
    pin(8'h01);
  endtask : t_tach
  task automatic t_lowpower();
    @(posedge clk);
    tach <= 4'h1;
    u_host.write_reg(8'h7c, 8'h0d);
    u_host.write_reg(8'h40, 8'h00);
    pin(8'h01);
    chk("halt bias", 8'h03, {6'h00, halt, bias});
    chk("fan_full", 8'h07, {5'h00, ffull});
    rc(8'h80, 8'h01);
    @(posedge clk);
    vid <= 5'h15;
    repeat (5) @(posedge clk);
    rc(8'h43, 8'h15);
    u_host.write_reg(8'h7f, 8'h80);
    rc(8'h42, 8'h00);
    rc(8'h7f, 8'h00);
  endtask : t_lowpower
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_volt();
    t_diode();
    t_tach();
    t_lowpower();
    summarize();
  end
endmodule : testbench
